/* rtl/blcs_defines.vh */
// How it works
// R1: Config bit 7 set picks the second light sensor, clear picks the main sensor.
// R2: Config bit 6 set enables second sensor and turns sink six off.
// R3: Config bits 5 to 3 report the brightness level; software may force it.
// R4: With auto comparator enabled, hardware rewrites the level field, overriding software.
// R5: Level codes 000 to 100 mean levels one (daylight) to five (dark).
// R6: Level codes 101 to 111 disable the backlight, current target zero.
// R7: Transfer law 00 or 01 gives square-law current with linear time steps.
// R8: Transfer law 10 or 11 gives nonlinear steps, cubic profile 10 or 11.
// R9: Config bit 0 set enables the fade override, clear disables it.
// R10: With fade override on, a new current target applies at once, no stepping.
// R11: Selection bits 0 to 6 map sinks one to seven; 1 means independent.
// R12: Selection bit 0 ties that sink to the shared backlight group enable.
`ifndef BLCS_DEFINES_VH
`define BLCS_DEFINES_VH

// Register offsets
`define BLCS_CFG_ADDR 8'h04
`define BLCS_SEL_ADDR 8'h05

// Configuration field positions
`define BLCS_CFG_INSEL_BIT 7
`define BLCS_CFG_SEN2_BIT 6
`define BLCS_CFG_LVL_HI 5
`define BLCS_CFG_LVL_LO 3
`define BLCS_CFG_LAW_HI 2
`define BLCS_CFG_LAW_LO 1
`define BLCS_CFG_FADE_OVERRIDE_BIT 0

// Selection register layout
`define BLCS_SEL_MASK 8'h7f
`define BLCS_SINK_SIX_IDX 5

// Reset values
`define BLCS_CFG_RESET 8'h00
`define BLCS_SEL_RESET 8'h00

// Highest valid brightness code
`define BLCS_LVL_MAX 3'h4

`endif

/* rtl/blcs_backlight_config.v */
`include "blcs_defines.vh"

module blcs_backlight_config #(
    parameter SINKS = 7,
    parameter CURW = 7
) (
    input wire clk,
    input wire reset,
    // Register port from the serial interface
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    // Ambient light zones from the comparator logic
    input wire auto_comparator_enable,
    input wire [2:0] main_sensor_level,
    input wire [2:0] second_sensor_level,
    // Per-level current settings, level one in the low bits
    input wire [5*CURW-1:0] level_currents,
    // One-cycle fade step enable from the fade timer
    input wire fade_tick,
    // Sink drive sources
    input wire backlight_group_enable,
    input wire [SINKS-1:0] independent_enable,
    // Results
    output reg second_sensor_enable,
    output reg light_input_select,
    output reg [4:0] level_onehot,
    output reg backlight_active,
    output reg fade_nonlinear,
    output reg cubic_profile,
    output reg fade_override,
    output reg [CURW-1:0] current_target,
    output reg [CURW-1:0] current_out,
    output reg [SINKS-1:0] sink_enable
);

    // Checks a brightness code for one of the five valid levels
    function level_ok;
        input [2:0] code;
        begin
            level_ok = (code <= `BLCS_LVL_MAX);
        end
    endfunction

    // Picks the current setting for a code, zero for the disabled codes
    function [CURW-1:0] level_current;
        input [2:0] code;
        input [5*CURW-1:0] table_in;
        begin
            if (level_ok(code)) begin
                level_current = table_in[code*CURW +: CURW];
            end else begin
                level_current = {CURW{1'b0}};
            end
        end
    endfunction

    reg [7:0] cfg_reg;
    reg [7:0] cfg_next;
    reg [7:0] sel_reg;
    reg [7:0] sel_next;
    reg [2:0] sensor_level;
    reg [CURW-1:0] target_next;
    reg [CURW-1:0] current_next;
    reg [SINKS-1:0] sink_next;
    reg [4:0] onehot_next;
    integer i;

    wire [2:0] lvl_field = cfg_reg[`BLCS_CFG_LVL_HI:`BLCS_CFG_LVL_LO];
    wire [1:0] law_field = cfg_reg[`BLCS_CFG_LAW_HI:`BLCS_CFG_LAW_LO];

    // Zone from the sensor that governs the backlight
    always @* begin
        if (cfg_reg[`BLCS_CFG_INSEL_BIT]) begin
            sensor_level = second_sensor_level; // R1
        end else begin
            sensor_level = main_sensor_level; // R1
        end
    end

    // Configuration register next value
    always @* begin
        cfg_next = cfg_reg;
        if (reg_wr && reg_addr == `BLCS_CFG_ADDR) begin
            cfg_next = reg_wdata; // R3
        end
        if (auto_comparator_enable) begin
            // Hardware level wins over a software write in the same cycle
            cfg_next[`BLCS_CFG_LVL_HI:`BLCS_CFG_LVL_LO] = sensor_level; // R4
        end
    end

    // Selection register next value, reserved bit held at zero
    always @* begin
        sel_next = sel_reg;
        if (reg_wr && reg_addr == `BLCS_SEL_ADDR) begin
            sel_next = reg_wdata & `BLCS_SEL_MASK; // R11
        end
    end

    // Register storage
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= `BLCS_CFG_RESET;
            sel_reg <= `BLCS_SEL_RESET;
        end else begin
            cfg_reg <= cfg_next;
            sel_reg <= sel_next;
        end
    end

    // Register read port, data one cycle after the request
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `BLCS_CFG_ADDR: reg_rdata <= cfg_reg; // R3
                    `BLCS_SEL_ADDR: reg_rdata <= sel_reg;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Level decode into one line per zone
    always @* begin
        onehot_next = 5'h00;
        case (lvl_field)
            3'h0: onehot_next = 5'h01; // R5
            3'h1: onehot_next = 5'h02; // R5
            3'h2: onehot_next = 5'h04; // R5
            3'h3: onehot_next = 5'h08; // R5
            3'h4: onehot_next = 5'h10; // R5
            default: onehot_next = 5'h00; // R6
        endcase
    end

    // Target current, zero for the disabled codes
    always @* begin
        target_next = level_current(lvl_field, level_currents); // R6
    end

    // Fade stepping toward the target, or a jump under override
    always @* begin
        current_next = current_out;
        if (cfg_reg[`BLCS_CFG_FADE_OVERRIDE_BIT]) begin
            current_next = current_target; // R10
        end else if (fade_tick) begin
            if (current_out < current_target) begin
                current_next = current_out + {{(CURW-1){1'b0}}, 1'b1};
            end else if (current_out > current_target) begin
                current_next = current_out - {{(CURW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Sink drive: own enable or the shared group enable, sink six held off while config bit 6 is set
    always @* begin
        for (i = 0; i < SINKS; i = i + 1) begin
            if (sel_reg[i]) begin
                sink_next[i] = independent_enable[i]; // R11
            end else begin
                sink_next[i] = backlight_group_enable; // R12
            end
        end
        if (cfg_reg[`BLCS_CFG_SEN2_BIT]) begin
            sink_next[`BLCS_SINK_SIX_IDX] = 1'b0; // R2
        end
    end

    // Output flops
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            second_sensor_enable <= 1'b0;
            light_input_select <= 1'b0;
            level_onehot <= 5'h00;
            backlight_active <= 1'b0;
            fade_nonlinear <= 1'b0;
            cubic_profile <= 1'b0;
            fade_override <= 1'b0;
            current_target <= {CURW{1'b0}};
            current_out <= {CURW{1'b0}};
            sink_enable <= {SINKS{1'b0}};
        end else begin
            second_sensor_enable <= cfg_reg[`BLCS_CFG_SEN2_BIT]; // R2
            light_input_select <= cfg_reg[`BLCS_CFG_INSEL_BIT]; // R1
            level_onehot <= onehot_next;
            backlight_active <= level_ok(lvl_field); // R6
            // Law 0x is linear steps, 1x is cubic with profile in bit 0
            fade_nonlinear <= law_field[1]; // R7
            cubic_profile <= law_field[1] & law_field[0]; // R8
            fade_override <= cfg_reg[`BLCS_CFG_FADE_OVERRIDE_BIT]; // R9
            current_target <= target_next;
            current_out <= current_next;
            sink_enable <= sink_next;
        end
    end

endmodule // blcs_backlight_config

/* testbench/blcs_props_properties.sv */
module blcs_props #(parameter SINKS = 7, parameter CURW = 7) (
    input wire clk, input wire reset, input wire reg_rd, input wire reg_rvalid,
    input wire [7:0] reg_rdata, input wire fade_tick, input wire second_sensor_enable,
    input wire [4:0] level_onehot, input wire backlight_active, input wire fade_nonlinear,
    input wire cubic_profile, input wire fade_override,
    input wire [CURW-1:0] current_target, input wire [CURW-1:0] current_out,
    input wire [SINKS-1:0] sink_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Override seen on two edges in a row
    sequence s_ovr_held; fade_override ##1 fade_override; endsequence
    property p_rv; reg_rvalid == $past(reg_rd); endproperty
    a_rv: assert property (p_rv) else $error("read valid timing");
    property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_off; !backlight_active |-> level_onehot == 5'h00 && current_target == '0; endproperty
    a_off: assert property (p_off) else $error("disabled level drives current");
    property p_on; backlight_active |-> $onehot(level_onehot); endproperty
    a_on: assert property (p_on) else $error("level decode");
    property p_law; cubic_profile |-> fade_nonlinear; endproperty
    a_law: assert property (p_law) else $error("cubic without nonlinear");
    property p_six; second_sensor_enable |-> !sink_enable[5]; endproperty
    a_six: assert property (p_six) else $error("sink six on");
    property p_ovr; s_ovr_held |-> current_out == $past(current_target); endproperty
    a_ovr: assert property (p_ovr) else $error("override not immediate");
    property p_step;
        fade_tick && !fade_override && current_out < current_target
            |=> current_out == $past(current_out) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("fade step");
endmodule // blcs_props

/* testbench/blcs_host.sv */
module blcs_host (
    input wire clk, output logic [7:0] reg_addr, output logic reg_wr,
    output logic [7:0] reg_wdata, output logic reg_rd, input wire [7:0] reg_rdata,
    input wire reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    end
    // One write strobe, data scrambled once released
    task wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk); #1; reg_addr = a; reg_wdata = dat; reg_wr = 1;
        @(posedge clk); #1; reg_wr = 0; reg_wdata = ~dat;
    endtask
    // One read strobe, answer taken one edge later
    task rd(input logic [7:0] a, output logic [7:0] dat, output logic v);
        @(posedge clk); #1; reg_addr = a; reg_rd = 1;
        @(posedge clk); #1; reg_rd = 0; dat = reg_rdata; v = reg_rvalid;
    endtask
endmodule // blcs_host

/* testbench/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, auto = 0, tick = 0, grp = 0, v;
    logic [2:0] lv1 = 3'h2, lv2 = 3'h4;
    logic [6:0] ind = 7'h0f;
    logic [34:0] cur = {7'h32, 7'h28, 7'h1e, 7'h14, 7'h0a};
    logic [7:0] d;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, rv, se, ls, act, nl, cub, ovr;
    wire [4:0] oh;
    wire [6:0] tgt, cout, sink;
    int errors = 0, num_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    blcs_host host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
        .reg_rdata(rdata), .reg_rvalid(rv));
    blcs_backlight_config dut (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rv),
        .auto_comparator_enable(auto), .main_sensor_level(lv1), .second_sensor_level(lv2),
        .level_currents(cur), .fade_tick(tick), .backlight_group_enable(grp),
        .independent_enable(ind), .second_sensor_enable(se), .light_input_select(ls),
        .level_onehot(oh), .backlight_active(act), .fade_nonlinear(nl), .cubic_profile(cub),
        .fade_override(ovr), .current_target(tgt), .current_out(cout), .sink_enable(sink));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task finish_test;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            errors++;
            finish_test;
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1 reset = 0;
        rchk(8'h04, 8'h00);
        rchk(8'h05, 8'h00);
        host.wr(8'h06, 8'hff);
        rchk(8'h06, 8'h00);
        host.wr(8'h05, 8'hd5);
        rchk(8'h05, 8'h55);
        grp = 1;
        settle;
        chk({1'b0, sink}, 8'h2f);
        host.wr(8'h04, 8'h40);
        settle;
        chk({1'b0, sink}, 8'h0f);
        chk({7'h00, se}, 8'h01);
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h04, {2'b00, c[2:0], c[1:0], 1'b0});
            settle;
            chk({3'h0, oh}, c < 5 ? 8'h01 << c : 8'h00);
            chk({7'h00, act}, c < 5 ? 8'h01 : 8'h00);
            chk({1'b0, tgt}, c < 5 ? 8'(c * 10 + 10) : 8'h00);
            chk({6'h00, nl, cub}, {6'h00, c[1], c[1:0] == 2'b11});
        end
        auto = 1;
        host.wr(8'h04, 8'h80);
        rchk(8'h04, 8'ha0);
        chk({7'h00, ls}, 8'h01);
        host.wr(8'h04, 8'h00);
        rchk(8'h04, 8'h10);
        auto = 0;
        host.wr(8'h04, 8'h01);
        settle;
        chk({7'h00, ovr}, 8'h01);
        chk({1'b0, cout}, 8'h0a);
        host.wr(8'h04, 8'h20);
        settle;
        chk({1'b0, cout}, 8'h0a);
        repeat (3) begin
            @(posedge clk); #1 tick = 1;
            @(posedge clk); #1 tick = 0;
        end
        chk({1'b0, cout}, 8'h0d);
        finish_test;
    end
endmodule // testbench
bind blcs_backlight_config blcs_props #(.SINKS(SINKS), .CURW(CURW)) u_props (.clk, .reset,
    .reg_rd, .reg_rvalid, .reg_rdata, .fade_tick, .second_sensor_enable, .level_onehot,
    .backlight_active, .fade_nonlinear, .cubic_profile, .fade_override, .current_target,
    .current_out, .sink_enable);
